// ### jtp_pkg.sv
// Package for the test access port pin block: TAP states, instruction codes,
// reset values and register widths.
// Assumes a single system clock that samples every test-port pin.
package jtp_pkg;

	// Sixteen controller states, one-hot
	typedef enum logic [15:0] {
		ST_TLR     = 16'h0001, // Test-Logic-Reset
		ST_RTI     = 16'h0002, // Run-Test/Idle
		ST_SEL_DR  = 16'h0004, // Select-DR-Scan
		ST_CAP_DR  = 16'h0008, // Capture-DR
		ST_SHF_DR  = 16'h0010, // Shift-DR
		ST_EX1_DR  = 16'h0020, // Exit1-DR
		ST_PAU_DR  = 16'h0040, // Pause-DR
		ST_EX2_DR  = 16'h0080, // Exit2-DR
		ST_UPD_DR  = 16'h0100, // Update-DR
		ST_SEL_IR  = 16'h0200, // Select-IR-Scan
		ST_CAP_IR  = 16'h0400, // Capture-IR
		ST_SHF_IR  = 16'h0800, // Shift-IR
		ST_EX1_IR  = 16'h1000, // Exit1-IR
		ST_PAU_IR  = 16'h2000, // Pause-IR
		ST_EX2_IR  = 16'h4000, // Exit2-IR
		ST_UPD_IR  = 16'h8000  // Update-IR
	} jtp_state_t;

	localparam int          IR_W        = 4;       // Instruction register width
	localparam int          ID_W        = 32;      // Identification register width
	localparam logic [3:0]  OP_BYPASS   = 4'hF;    // All ones selects bypass
	localparam logic [3:0]  OP_IDCODE   = 4'h2;    // Arbitrary code for identification
	localparam logic [3:0]  IR_CAPTURE  = 4'h1;    // Fixed pattern loaded in Capture-IR
	localparam logic [31:0] IDCODE_VAL  = 32'h1234_5001; // Arbitrary value, not a real part
	localparam logic [2:0]  TLR_ONES    = 3'h5;    // High mode-select samples forcing reset
	localparam logic        TDO_RST     = 1'h0;    // Output data value after reset
	localparam logic        PULL_ON     = 1'h1;    // Pull enabled after reset
endpackage

// ### jtp_tap_pins.sv
// Test access port behind the test pins: synchronises the test clock and
// inputs, runs the controller, shifts instruction and data, drives test out.
// Assumes sys_clk is well above twice the test clock rate (20 MHz vs 2.5 MHz).
// Assumes test reset is driven low at power-up; chip reset leaves the controller alone.
`timescale 1ns/1ns

// Summary of operation
// - Test clock edges time the controller and shift logic; pulled low
// - Mode select sampled on test clock rise
// - Data input sampled on test clock rise
// - Data output driven only in shift states
// - Data output changes on falling edge or chip reset only
// - Low test reset resets controller, clock-free
// - Pull disable bit removes input pull-ups
module jtp_tap_pins (
	input  wire logic             sys_clk,       // System clock, 20 MHz
	input  wire logic             rst,           // Synchronous reset, active high
	input  wire logic             tck,           // Test clock pin
	input  wire logic             tms,           // Mode select pin
	input  wire logic             tdi,           // Test data in pin
	input  wire logic             trst_n,        // Test reset pin, active low
	input  wire logic             jtag_pull_dis, // Pull disable bit of system_pullup_disable_reg
	output logic                  tdo,           // Test data out value
	output logic                  tdo_oe,        // Test data out enable, high drives pin
	output logic                  tck_pd_en,     // Test clock pull-down enable
	output logic                  tms_pu_en,     // Mode select pull-up enable
	output logic                  tdi_pu_en,     // Data in pull-up enable
	output logic                  trst_pu_en,    // Test reset pull-up enable
	output jtp_pkg::jtp_state_t   tap_state,     // Current controller state
	output logic [jtp_pkg::IR_W-1:0] instr       // Active instruction
);

	// Two-stage synchronisers for all pins; third tck stage feeds edge detect
	logic [1:0] tck_sy;    // Test clock sync chain
	logic       tck_d;     // Delayed synced clock, edge reference
	logic [1:0] tms_sy;    // Mode select sync chain
	logic [1:0] tdi_sy;    // Data in sync chain
	logic [1:0] trst_sy;   // Test reset sync chain
	logic       tck_rise;  // One-cycle pulse on test clock rise
	logic       tck_fall;  // One-cycle pulse on test clock fall
	logic       tms_s;     // Synced mode select
	logic       tdi_s;     // Synced data in
	logic       trst_s_n;  // Synced test reset, active low

	// Sync flops; first stage read only by second
	// No chip reset here: clearing the chain mid-run would fake a clock edge
	always_ff @(posedge sys_clk) begin
		tck_sy  <= {tck_sy[0], tck};
		tck_d   <= tck_sy[1];
		tms_sy  <= {tms_sy[0], tms};
		tdi_sy  <= {tdi_sy[0], tdi};
		trst_sy <= {trst_sy[0], trst_n};
	end

	assign tck_rise = tck_sy[1] & ~tck_d;
	assign tck_fall = ~tck_sy[1] & tck_d;
	assign tms_s    = tms_sy[1];
	assign tdi_s    = tdi_sy[1];
	assign trst_s_n = trst_sy[1];

	// Controller and shift state
	jtp_pkg::jtp_state_t      state_reg, state_next;     // Controller state
	logic [jtp_pkg::IR_W-1:0] ir_sh_reg, ir_sh_next;     // Instruction shift stage
	logic [jtp_pkg::IR_W-1:0] ir_reg, ir_next;           // Active instruction
	logic [jtp_pkg::ID_W-1:0] id_sh_reg, id_sh_next;     // Identification shift stage
	logic                     byp_reg, byp_next;         // Bypass bit
	logic                     tdo_reg, tdo_next;         // Output data
	logic                     oe_reg, oe_next;           // Output enable
	logic                     pull_reg, pull_next;       // Input pull-ups on
	logic                     shifting;                  // In a shift state
	logic                     dr_bit;                    // Selected data register out

	// Next controller state on a test clock rise
	function automatic jtp_pkg::jtp_state_t tap_step(jtp_pkg::jtp_state_t s, logic m);
		unique case (s)
			jtp_pkg::ST_TLR:    tap_step = m ? jtp_pkg::ST_TLR    : jtp_pkg::ST_RTI;
			jtp_pkg::ST_RTI:    tap_step = m ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_RTI;
			jtp_pkg::ST_SEL_DR: tap_step = m ? jtp_pkg::ST_SEL_IR : jtp_pkg::ST_CAP_DR;
			jtp_pkg::ST_CAP_DR: tap_step = m ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SHF_DR;
			jtp_pkg::ST_SHF_DR: tap_step = m ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SHF_DR;
			jtp_pkg::ST_EX1_DR: tap_step = m ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_PAU_DR;
			jtp_pkg::ST_PAU_DR: tap_step = m ? jtp_pkg::ST_EX2_DR : jtp_pkg::ST_PAU_DR;
			jtp_pkg::ST_EX2_DR: tap_step = m ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_SHF_DR;
			jtp_pkg::ST_UPD_DR: tap_step = m ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_RTI;
			jtp_pkg::ST_SEL_IR: tap_step = m ? jtp_pkg::ST_TLR    : jtp_pkg::ST_CAP_IR;
			jtp_pkg::ST_CAP_IR: tap_step = m ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SHF_IR;
			jtp_pkg::ST_SHF_IR: tap_step = m ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SHF_IR;
			jtp_pkg::ST_EX1_IR: tap_step = m ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_PAU_IR;
			jtp_pkg::ST_PAU_IR: tap_step = m ? jtp_pkg::ST_EX2_IR : jtp_pkg::ST_PAU_IR;
			jtp_pkg::ST_EX2_IR: tap_step = m ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_SHF_IR;
			jtp_pkg::ST_UPD_IR: tap_step = m ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_RTI;
			default:            tap_step = jtp_pkg::ST_TLR; // Illegal code recovers
		endcase
	endfunction

	assign shifting = (state_reg == jtp_pkg::ST_SHF_IR) || (state_reg == jtp_pkg::ST_SHF_DR);
	assign dr_bit   = (ir_reg == jtp_pkg::OP_BYPASS) ? byp_reg : id_sh_reg[0];

	// Next values of controller, shift stages and pin drivers
	always_comb begin
		state_next = state_reg;
		ir_sh_next = ir_sh_reg;
		ir_next    = ir_reg;
		id_sh_next = id_sh_reg;
		byp_next   = byp_reg;
		tdo_next   = tdo_reg;
		oe_next    = oe_reg;
		pull_next  = ~jtag_pull_dis;
		if (!trst_s_n) begin
			// Test reset wins regardless of clock activity
			state_next = jtp_pkg::ST_TLR;
			ir_next    = jtp_pkg::OP_IDCODE;
			ir_sh_next = jtp_pkg::IR_CAPTURE;
			id_sh_next = jtp_pkg::IDCODE_VAL;
			byp_next   = 1'h0;
			oe_next    = 1'h0;
		end else if (tck_rise) begin
			// Register actions use the state before the step
			unique case (state_reg)
				jtp_pkg::ST_TLR: begin
					ir_next = jtp_pkg::OP_IDCODE;
				end
				jtp_pkg::ST_CAP_IR: begin
					ir_sh_next = jtp_pkg::IR_CAPTURE;
				end
				jtp_pkg::ST_SHF_IR: begin
					ir_sh_next = {tdi_s, ir_sh_reg[jtp_pkg::IR_W-1:1]};
				end
				jtp_pkg::ST_UPD_IR: begin
					ir_next = ir_sh_reg;
				end
				jtp_pkg::ST_CAP_DR: begin
					byp_next   = 1'h0;
					id_sh_next = jtp_pkg::IDCODE_VAL;
				end
				jtp_pkg::ST_SHF_DR: begin
					byp_next   = tdi_s;
					id_sh_next = {tdi_s, id_sh_reg[jtp_pkg::ID_W-1:1]};
				end
				default: begin
				end
			endcase
			state_next = tap_step(state_reg, tms_s);
		end else if (tck_fall) begin
			// Output moves half a cycle ahead of the host's rising sample
			oe_next  = shifting;
			tdo_next = (state_reg == jtp_pkg::ST_SHF_IR) ? ir_sh_reg[0] : dr_bit;
		end
	end

	// Registers only; the controller answers to test reset alone, so a chip
	// reset during debugging leaves it where it was
	always_ff @(posedge sys_clk) begin
		state_reg <= state_next;
		ir_sh_reg <= ir_sh_next;
		ir_reg    <= ir_next;
		id_sh_reg <= id_sh_next;
		byp_reg   <= byp_next;
		oe_reg    <= oe_next;
	end

	// Chip-side values: pulls and the output data bit start defined on chip reset
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tdo_reg  <= jtp_pkg::TDO_RST;
			pull_reg <= jtp_pkg::PULL_ON;
		end else begin
			tdo_reg  <= tdo_next;
			pull_reg <= pull_next;
		end
	end

	assign tdo        = tdo_reg;
	assign tdo_oe     = oe_reg;
	assign tck_pd_en  = 1'h1;
	assign tms_pu_en  = pull_reg;
	assign tdi_pu_en  = pull_reg;
	assign trst_pu_en = pull_reg;
	assign tap_state  = state_reg;
	assign instr      = ir_reg;

	// Helper: count consecutive high mode-select samples
	logic [2:0] ones_cnt;
	always_ff @(posedge sys_clk) begin
		if (!trst_s_n) begin
			ones_cnt <= 3'h0;
		end else if (tck_rise) begin
			ones_cnt <= !tms_s ? 3'h0 : (ones_cnt == jtp_pkg::TLR_ONES) ? ones_cnt : ones_cnt + 3'h1;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_fall_in_shift;
		tck_fall && trst_s_n && shifting;
	endsequence
	sequence s_shift_dr_bypass;
		tck_rise && trst_s_n && state_reg == jtp_pkg::ST_SHF_DR && ir_reg == jtp_pkg::OP_BYPASS;
	endsequence

	chk_tdo_fall_only: assert property ($changed(tdo_reg) |-> $past(tck_fall))
		else $error("test data out changed without a test clock fall");
	chk_oe_shift_on: assert property (s_fall_in_shift |=> oe_reg)
		else $error("output not enabled after fall in shift state");
	chk_oe_shift_off: assert property (oe_reg && !$past(oe_reg) |-> $past(shifting))
		else $error("output enabled outside shift state");
	chk_trst_tlr: assert property (!trst_s_n |=> state_reg == jtp_pkg::ST_TLR && !oe_reg)
		else $error("test reset did not force reset state");
	chk_state_hold: assert property (!tck_rise && trst_s_n |=> $stable(state_reg))
		else $error("controller moved without a test clock rise");
	chk_five_ones: assert property (tck_rise && tms_s && trst_s_n
		&& ones_cnt >= jtp_pkg::TLR_ONES - 3'h1
		|=> state_reg == jtp_pkg::ST_TLR)
		else $error("five high mode samples did not reach reset state");
	chk_tdi_bypass: assert property (s_shift_dr_bypass |=> byp_reg == $past(tdi_s))
		else $error("bypass bit did not take test data in");
	chk_pull_follow: assert property (##1 tms_pu_en == !$past(jtag_pull_dis)
		&& trst_pu_en == tms_pu_en)
		else $error("pull-up enable does not follow disable bit");
	chk_tck_edge: assert property (tck_rise |-> ##1 !tck_rise ##1 tck_sy[1])
		else $error("test clock rise not a clean edge");
endmodule

// ### jtp_host_model.sv
// Host model for the test port: drives test clock, mode select, data in, test reset.
// Assumes the bench resolves the data out pin with a pull-up when released.
`timescale 1ns/1ns
module jtp_host_model (
	input  wire logic sys_clk,   // Bench clock that paces the link
	input  wire logic tdo_pin,   // Resolved data out pin
	output logic      tck,       // Test clock, stands still between frames
	output logic      tms,       // Mode select
	output logic      tdi,       // Test data in
	output logic      trst_n,    // Test reset, active low
	output int        n_unstable // Data out changes seen in the high half
);
	// Power-up: test reset held along with chip reset
	initial begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h1;
		trst_n = 1'h0;
		n_unstable = 0;
	end
	// Wait n clocks, then step off the edge
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
		#5;
	endtask
	// Test reset low for n clocks, test clock still
	task automatic tap_reset(input int n);
		trst_n = 1'h0;
		wt(n);
		trst_n = 1'h1;
		wt(4);
	endtask
	// One 400 ns period; inputs move with the fall so they are steady at the rise
	task automatic pulse(input logic m, input logic d, output logic o);
		tck = 1'h0;
		tms = m;
		tdi = d;
		wt(4);
		tck = 1'h1;
		wt(2);
		o = tdo_pin; // Midway through the high half: the port answers up to 150 ns after the fall
		wt(2);
		if (tdo_pin !== o) n_unstable++;
	endtask
	// Shift n bits LSB first, leaving the shift state on the last
	task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
		logic o;
		dout = '0;
		for (int i = 0; i < n; i++) begin
			pulse(i == n - 1, din[i], o);
			dout[i] = o;
		end
	endtask
	// Walk n mode-select values, first one in bit 0
	task automatic walk(input logic [15:0] path, input int n);
		logic o;
		for (int i = 0; i < n; i++) pulse(path[i], 1'h1, o);
	endtask
	// Close a frame with the clock at rest low
	task automatic rest();
		tck = 1'h0;
		wt(8);
	endtask
endmodule

// ### jtp_tap_pins_tb_top.sv
// Bench for the test port pins: host model on the pins, checks at the ports.
// Assumes the design's package is compiled first.
`timescale 1ns/1ns
module jtp_tap_pins_tb_top;
	logic sys_clk = 1'h0;
	logic rst, jtag_pull_dis, tck, tms, tdi, trst_n, tdo, tdo_oe;
	logic tck_pd_en, tms_pu_en, tdi_pu_en, trst_pu_en;
	logic [3:0] instr;
	jtp_pkg::jtp_state_t tap_state;
	int n_unstable;
	int miscompares = 0;
	int n_checks = 0;
	tri1 tdo_pin; // Pulled up whenever the port lets go
	assign tdo_pin = tdo_oe ? tdo : 1'bz;
	jtp_tap_pins DUT (.sys_clk(sys_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
		.trst_n(trst_n), .jtag_pull_dis(jtag_pull_dis), .tdo(tdo), .tdo_oe(tdo_oe),
		.tck_pd_en(tck_pd_en), .tms_pu_en(tms_pu_en), .tdi_pu_en(tdi_pu_en),
		.trst_pu_en(trst_pu_en), .tap_state(tap_state), .instr(instr));
	jtp_host_model host (.sys_clk(sys_clk), .tdo_pin(tdo_pin), .tck(tck), .tms(tms),
		.tdi(tdi), .trst_n(trst_n), .n_unstable(n_unstable));
	// 20 MHz clock
	always #25 sys_clk = ~sys_clk;
	// Compare one value, four-state exact
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t %s: got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic t_reset();
		chk(tap_state, jtp_pkg::ST_TLR, "reset state");
		chk(instr, jtp_pkg::OP_IDCODE, "reset instr");
		chk(tdo_oe, 1'h0, "reset oe");
		chk({tck_pd_en, tms_pu_en, tdi_pu_en, trst_pu_en}, 4'hF, "pulls");
		$display("test reset done");
	endtask
	task automatic t_pull();
		jtag_pull_dis = 1'h1;
		host.wt(2);
		chk({tms_pu_en, tdi_pu_en, trst_pu_en, tck_pd_en}, 4'h1, "pulls off");
		jtag_pull_dis = 1'h0;
		host.wt(2);
		chk({tms_pu_en, tdi_pu_en, trst_pu_en, tck_pd_en}, 4'hF, "pulls on");
		$display("test pull done");
	endtask
	task automatic t_idcode();
		logic [31:0] d;
		host.walk(16'h0002, 4);
		chk(tap_state, jtp_pkg::ST_SHF_DR, "enter shift");
		host.shift(32, 32'h0000_0000, d);
		chk(tdo_oe, 1'h1, "oe in shift");
		chk(d, jtp_pkg::IDCODE_VAL, "id bits");
		host.rest();
		chk(tdo_oe, 1'h0, "oe after shift");
		chk(tap_state, jtp_pkg::ST_EX1_DR, "exit1");
		$display("test idcode done");
	endtask
	task automatic t_bypass();
		logic [31:0] d;
		host.walk(16'h0007, 5);
		host.shift(4, 32'h0000_000F, d);
		chk(d, jtp_pkg::IR_CAPTURE, "ir capture");
		host.walk(16'h0003, 4);
		chk(instr, jtp_pkg::OP_BYPASS, "bypass loaded");
		host.shift(8, 32'h0000_00A5, d);
		chk(d, 32'h0000_004A, "bypass bits");
		host.rest();
		$display("test bypass done");
	endtask
	// Chip reset alone with test reset high: the port keeps its state
	task automatic t_dbg_rst();
		rst = 1'h1;
		host.wt(4);
		rst = 1'h0;
		host.wt(2);
		chk(tap_state, jtp_pkg::ST_EX1_DR, "state kept");
		chk(instr, jtp_pkg::OP_BYPASS, "instr kept");
		$display("test dbg reset done");
	endtask
	task automatic t_trst();
		host.walk(16'h0001, 1);
		chk(tap_state, jtp_pkg::ST_UPD_DR, "update");
		host.rest();
		host.tap_reset(3);
		chk(tap_state, jtp_pkg::ST_TLR, "test reset");
		chk(instr, jtp_pkg::OP_IDCODE, "instr reset");
		$display("test trst done");
	endtask
	task automatic t_ones();
		host.walk(16'h01F2, 9);
		chk(tap_state, jtp_pkg::ST_TLR, "five ones");
		host.rest();
		$display("test ones done");
	endtask
	// Main sequence: chip reset and test reset together
	initial begin
		rst = 1'h1;
		jtag_pull_dis = 1'h0;
		repeat (20) @(posedge sys_clk);
		#5;
		rst = 1'h0;
		host.tap_reset(3);
		t_reset();
		t_pull();
		t_idcode();
		t_bypass();
		t_dbg_rst();
		t_trst();
		t_ones();
		chk(n_unstable, 0, "out steady while high");
		complete_run();
	end
	// Watchdog, well past the roughly 600 cycles of the tests
	initial begin
		#1000000;
		miscompares++;
		complete_run();
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
endmodule
